// ### design/usehc_pkg.sv
// register map, field positions and handshake codes for the small endpoint handshake controller
// assumes a 32-bit AXI4-Lite master; each 8-bit register sits at byte address 4*index
package usehc_pkg;
  localparam int AW    = 18;
  localparam int CNT_W = 7;
  localparam int N_LEP = 4;

  // register indices; byte address is index * 4
  localparam logic [15:0] IDX_LEP_STAT    = 16'h00aa;
  localparam logic [15:0] IDX_IN_PKT_END  = 16'he648;
  localparam logic [15:0] IDX_OUT_PKT_END = 16'he649;
  localparam logic [15:0] IDX_CS_IRQ_EN   = 16'he65c;
  localparam logic [15:0] IDX_CS_IRQ_REQ  = 16'he65d;
  localparam logic [15:0] IDX_SEP_BUSY    = 16'h00ba;
  localparam logic [15:0] IDX_EP0_CS      = 16'he6a0;
  localparam logic [15:0] IDX_EP0_CNT_LO  = 16'he68b;
  localparam logic [15:0] IDX_EP1O_CS     = 16'he6a1;
  localparam logic [15:0] IDX_EP1O_CNT    = 16'he68d;
  localparam logic [15:0] IDX_EP1I_CS     = 16'he6a2;
  localparam logic [15:0] IDX_EP1I_CNT    = 16'he68f;
  localparam logic [15:0] IDX_EP1_IRQ     = 16'h0010;
  localparam logic [15:0] IDX_ISO    [N_LEP] = '{16'he640, 16'he641, 16'he642, 16'he643};
  localparam logic [15:0] IDX_CNT_HI [N_LEP] = '{16'he690, 16'he694, 16'he698, 16'he69c};
  localparam logic [15:0] IDX_CNT_LO [N_LEP] = '{16'he691, 16'he695, 16'he699, 16'he69d};
  localparam logic [15:0] IDX_LCS    [N_LEP] = '{16'he6a3, 16'he6a4, 16'he6a5, 16'he6a6};

  // control stage request and enable bits
  localparam int B_SETUP_TOKEN_IRQ = 0;
  localparam int B_SETUP_BYTES_READY_IRQ = 1;
  localparam int B_ACK   = 2;
  // busy copy bits
  localparam int B_EP0  = 0;
  localparam int B_EP1O = 1;
  localparam int B_EP1I = 2;
  // control/status bits
  localparam int B_STALL  = 0;
  localparam int B_BUSY   = 1;
  localparam int LB_EMPTY = 2;
  localparam int LB_FULL  = 3;
  // endpoint one request bits
  localparam int IRQ_EP1O = 0;
  localparam int IRQ_EP1I = 1;

  localparam logic [3:0] SETUP_BYTES = 4'h8;
  localparam logic [1:0] AXI_OKAY    = 2'h0;
  localparam logic [1:0] AXI_SLVERR  = 2'h2;

  typedef enum logic [1:0] {
    RESP_NAK   = 2'b00,
    RESP_ACK   = 2'b01,
    RESP_STALL = 2'b10,
    RESP_DATA  = 2'b11
  } usehc_resp_t;

  typedef struct packed {
    logic                   aw_full;
    logic [15:0]            aw_idx;
    logic                   w_full;
    logic [7:0]             w_data;
    logic                   w_lane0;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
    logic [2:0]             irq_en;
    logic [2:0]             irq_req;
    logic [3:0]             setup_cnt;
    logic                   ep0_busy;
    logic                   ep1o_busy;
    logic                   ep1o_stall;
    logic [CNT_W-1:0]       ep1o_cnt;
    logic                   ep1i_busy;
    logic                   ep1i_stall;
    logic [CNT_W-1:0]       ep1i_cnt;
    logic [1:0]             ep1_irq;
    logic [N_LEP-1:0][7:0]  iso;
    logic [N_LEP-1:0][7:0]  cnt_hi;
    logic [N_LEP-1:0][7:0]  cnt_lo;
    logic [N_LEP-1:0]       lep_stall;
    logic                   ipe_v;
    logic                   ope_v;
    logic [7:0]             ipe_data;
    logic [7:0]             ope_data;
  } usehc_state_t;
endpackage

// ### design/usehc_top.sv
// control-transfer requests, busy copies and endpoint one handshake logic, with large endpoint registers
// assumes serial engine strobes are one-cycle pulses on clk_sys; registers reached over AXI4-Lite
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps

module usehc_top
  import usehc_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              srst,
  input  wire logic              s_axi_awvalid,
  output      logic              s_axi_awready,
  input  wire logic [AW-1:0]     s_axi_awaddr,
  input  wire logic              s_axi_wvalid,
  output      logic              s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  output      logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output      logic [1:0]        s_axi_bresp,
  input  wire logic              s_axi_arvalid,
  output      logic              s_axi_arready,
  input  wire logic [AW-1:0]     s_axi_araddr,
  output      logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output      logic [31:0]       s_axi_rdata,
  output      logic [1:0]        s_axi_rresp,
  input  wire logic              sie_setup_tok,
  input  wire logic              sie_setup_byte_v,
  input  wire logic              sie_status_done,
  input  wire logic              sie_ep0_done,
  input  wire logic              sie_ep1o_tok,
  input  wire logic              sie_ep1o_ok,
  input  wire logic [CNT_W-1:0]  sie_ep1o_len,
  input  wire logic              sie_ep1i_tok,
  input  wire logic              sie_ep1i_ack,
  input  wire logic [N_LEP-1:0]  lep_full,
  input  wire logic [N_LEP-1:0]  lep_empty,
  output      usehc_resp_t       ep1o_resp,
  output      usehc_resp_t       ep1i_resp,
  output      logic [CNT_W-1:0]  ep1i_count,
  output      logic              ep0_busy,
  output      logic [2:0]        ctrl_irq_lines,
  output      logic [1:0]        ep1_irq_flags,
  output      logic [N_LEP-1:0]  lep_stall,
  output      logic              in_pkt_end_v,
  output      logic [7:0]        in_pkt_end_data,
  output      logic              out_pkt_end_v,
  output      logic [7:0]        out_pkt_end_data
);
  usehc_state_t s_r;
  usehc_state_t s_nxt;
  logic [7:0]   lep_stat;
  logic [2:0]   sep_busy;
  logic [15:0]  ridx;
  logic [7:0]   rd;
  logic         rhit;
  logic         whit;
  logic         wr_go;
  logic         we;

  // copies are pure wiring so a read can never see a stale value
  genvar g;
  generate
    for (g = 0; g < N_LEP; g++) begin : g_lep
      assign lep_stat[2*g]   = lep_empty[g];
      assign lep_stat[2*g+1] = lep_full[g];
    end
  endgenerate
  assign sep_busy[B_EP0]  = s_r.ep0_busy;
  assign sep_busy[B_EP1O] = s_r.ep1o_busy;
  assign sep_busy[B_EP1I] = s_r.ep1i_busy;

  assign ridx  = s_axi_araddr[AW-1:2];
  assign wr_go = s_r.aw_full & s_r.w_full & ~s_r.bvalid;
  assign we    = wr_go & s_r.w_lane0;

  assign s_axi_awready = ~s_r.aw_full;
  assign s_axi_wready  = ~s_r.w_full;
  assign s_axi_arready = ~s_r.rvalid;
  assign s_axi_bvalid  = s_r.bvalid;
  assign s_axi_bresp   = s_r.bresp;
  assign s_axi_rvalid  = s_r.rvalid;
  assign s_axi_rdata   = s_r.rdata;
  assign s_axi_rresp   = s_r.rresp;

  assign ep1i_count       = s_r.ep1i_cnt;
  assign ep0_busy         = s_r.ep0_busy;
  assign ctrl_irq_lines   = s_r.irq_en & s_r.irq_req;
  assign ep1_irq_flags    = s_r.ep1_irq;
  assign lep_stall        = s_r.lep_stall;
  assign in_pkt_end_v     = s_r.ipe_v;
  assign in_pkt_end_data  = s_r.ipe_data;
  assign out_pkt_end_v    = s_r.ope_v;
  assign out_pkt_end_data = s_r.ope_data;

  // stall outranks everything; an idle endpoint NAKs
  always_comb begin
    if (s_r.ep1o_stall) begin
      ep1o_resp = RESP_STALL;
    end else if (s_r.ep1o_busy && sie_ep1o_ok) begin
      ep1o_resp = RESP_ACK;
    end else begin
      ep1o_resp = RESP_NAK;
    end
    if (s_r.ep1i_stall) begin
      ep1i_resp = RESP_STALL;
    end else if (s_r.ep1i_busy) begin
      ep1i_resp = RESP_DATA;
    end else begin
      ep1i_resp = RESP_NAK;
    end
  end

  // read decode, live at the address phase
  always_comb begin
    rd   = 8'h00;
    rhit = 1'b1;
    if (ridx == IDX_LEP_STAT) begin
      rd = lep_stat;
    end else if (ridx == IDX_SEP_BUSY) begin
      rd = {5'h00, sep_busy};
    end else if (ridx == IDX_CS_IRQ_EN) begin
      rd = {5'h00, s_r.irq_en};
    end else if (ridx == IDX_CS_IRQ_REQ) begin
      rd = {5'h00, s_r.irq_req};
    end else if (ridx == IDX_EP0_CS) begin
      rd = {6'h00, s_r.ep0_busy, 1'b0};
    end else if (ridx == IDX_EP1O_CS) begin
      rd = {6'h00, s_r.ep1o_busy, s_r.ep1o_stall};
    end else if (ridx == IDX_EP1O_CNT) begin
      rd = {1'b0, s_r.ep1o_cnt};
    end else if (ridx == IDX_EP1I_CS) begin
      rd = {6'h00, s_r.ep1i_busy, s_r.ep1i_stall};
    end else if (ridx == IDX_EP1I_CNT) begin
      rd = {1'b0, s_r.ep1i_cnt};
    end else if (ridx == IDX_EP1_IRQ) begin
      rd = {6'h00, s_r.ep1_irq};
    end else if (ridx == IDX_IN_PKT_END || ridx == IDX_OUT_PKT_END || ridx == IDX_EP0_CNT_LO) begin
      rd = 8'h00;
    end else begin
      rhit = 1'b0;
    end
    for (int k = 0; k < N_LEP; k++) begin
      if (ridx == IDX_ISO[k]) begin
        rd   = s_r.iso[k];
        rhit = 1'b1;
      end
      if (ridx == IDX_CNT_HI[k]) begin
        rd   = s_r.cnt_hi[k];
        rhit = 1'b1;
      end
      if (ridx == IDX_CNT_LO[k]) begin
        rd   = s_r.cnt_lo[k];
        rhit = 1'b1;
      end
      if (ridx == IDX_LCS[k]) begin
        rd   = {4'h0, lep_full[k], lep_empty[k], 1'b0, s_r.lep_stall[k]};
        rhit = 1'b1;
      end
    end
  end

  always_comb begin
    s_nxt       = s_r;
    s_nxt.ipe_v = 1'b0;
    s_nxt.ope_v = 1'b0;
    whit        = 1'b1;
    if (s_axi_awvalid && !s_r.aw_full) begin
      s_nxt.aw_full = 1'b1;
      s_nxt.aw_idx  = s_axi_awaddr[AW-1:2];
    end
    if (s_axi_wvalid && !s_r.w_full) begin
      s_nxt.w_full  = 1'b1;
      s_nxt.w_data  = s_axi_wdata[7:0];
      s_nxt.w_lane0 = s_axi_wstrb[0];
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !s_r.rvalid) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata  = {24'h000000, rd};
      s_nxt.rresp  = rhit ? AXI_OKAY : AXI_SLVERR;
    end

    // hardware clears first so a same-cycle arm from software wins
    if (sie_setup_tok) begin
      s_nxt.setup_cnt = 4'h0;
      s_nxt.ep0_busy  = 1'b0;
    end else if (sie_setup_byte_v && s_r.setup_cnt != SETUP_BYTES) begin
      s_nxt.setup_cnt = s_r.setup_cnt + 4'h1;
    end
    if (sie_ep0_done) begin
      s_nxt.ep0_busy = 1'b0;
    end
    // a bad packet is NAKed and busy stays set; the host retries unaided
    if (sie_ep1o_tok && s_r.ep1o_busy && !s_r.ep1o_stall && sie_ep1o_ok) begin
      s_nxt.ep1o_busy = 1'b0;
      s_nxt.ep1o_cnt  = sie_ep1o_len;
    end
    if (sie_ep1i_ack && s_r.ep1i_busy && !s_r.ep1i_stall) begin
      s_nxt.ep1i_busy = 1'b0;
    end

    if (wr_go) begin
      s_nxt.aw_full = 1'b0;
      s_nxt.w_full  = 1'b0;
      s_nxt.bvalid  = 1'b1;
    end
    if (s_r.aw_idx == IDX_CS_IRQ_EN) begin
      if (we) s_nxt.irq_en = s_r.w_data[2:0];
    end else if (s_r.aw_idx == IDX_CS_IRQ_REQ) begin
      if (we) s_nxt.irq_req = s_r.irq_req & ~s_r.w_data[2:0];
    end else if (s_r.aw_idx == IDX_EP1_IRQ) begin
      if (we) s_nxt.ep1_irq = s_r.ep1_irq & ~s_r.w_data[1:0];
    end else if (s_r.aw_idx == IDX_EP0_CNT_LO) begin
      if (we) s_nxt.ep0_busy = 1'b1;
    end else if (s_r.aw_idx == IDX_EP1O_CS) begin
      if (we) s_nxt.ep1o_stall = s_r.w_data[B_STALL];
    end else if (s_r.aw_idx == IDX_EP1O_CNT) begin
      if (we) s_nxt.ep1o_busy = 1'b1;
    end else if (s_r.aw_idx == IDX_EP1I_CS) begin
      if (we) s_nxt.ep1i_stall = s_r.w_data[B_STALL];
    end else if (s_r.aw_idx == IDX_EP1I_CNT) begin
      if (we) begin
        s_nxt.ep1i_cnt  = s_r.w_data[CNT_W-1:0];
        s_nxt.ep1i_busy = 1'b1;
      end
    end else if (s_r.aw_idx == IDX_IN_PKT_END) begin
      if (we) begin
        s_nxt.ipe_v    = 1'b1;
        s_nxt.ipe_data = s_r.w_data;
      end
    end else if (s_r.aw_idx == IDX_OUT_PKT_END) begin
      if (we) begin
        s_nxt.ope_v    = 1'b1;
        s_nxt.ope_data = s_r.w_data;
      end
    end else if (s_r.aw_idx == IDX_LEP_STAT || s_r.aw_idx == IDX_SEP_BUSY || s_r.aw_idx == IDX_EP0_CS) begin
      whit = 1'b1;
    end else begin
      whit = 1'b0;
    end
    for (int k = 0; k < N_LEP; k++) begin
      if (s_r.aw_idx == IDX_ISO[k]) begin
        whit = 1'b1;
        if (we) s_nxt.iso[k] = s_r.w_data;
      end
      if (s_r.aw_idx == IDX_CNT_HI[k]) begin
        whit = 1'b1;
        if (we) s_nxt.cnt_hi[k] = s_r.w_data;
      end
      if (s_r.aw_idx == IDX_CNT_LO[k]) begin
        whit = 1'b1;
        if (we) s_nxt.cnt_lo[k] = s_r.w_data;
      end
      if (s_r.aw_idx == IDX_LCS[k]) begin
        whit = 1'b1;
        if (we) s_nxt.lep_stall[k] = s_r.w_data[B_STALL];
      end
    end
    if (wr_go) begin
      s_nxt.bresp = whit ? AXI_OKAY : AXI_SLVERR;
    end

    // sets after software clears: an event in the clearing cycle survives
    if (sie_setup_tok) s_nxt.irq_req[B_SETUP_TOKEN_IRQ] = 1'b1;
    if (!sie_setup_tok && sie_setup_byte_v && s_r.setup_cnt == SETUP_BYTES - 4'h1) begin
      s_nxt.irq_req[B_SETUP_BYTES_READY_IRQ] = 1'b1;
    end
    if (sie_status_done) s_nxt.irq_req[B_ACK] = 1'b1;
    if (s_r.ep1o_busy && !s_nxt.ep1o_busy) s_nxt.ep1_irq[IRQ_EP1O] = 1'b1;
    if (s_r.ep1i_busy && !s_nxt.ep1i_busy) s_nxt.ep1_irq[IRQ_EP1I] = 1'b1;
  end

  // reset leaves both endpoint one buffers unarmed
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  property p_setup_token_irq;
    sie_setup_tok |=> s_r.irq_req[B_SETUP_TOKEN_IRQ];
  endproperty
  a_setup_token_irq: assert property (p_setup_token_irq) else $error("setup token flag not set");

  property p_setup_bytes_ready_irq;
    $rose(s_r.irq_req[B_SETUP_BYTES_READY_IRQ]) |-> $past(s_r.setup_cnt) == SETUP_BYTES - 4'h1 && $past(sie_setup_byte_v);
  endproperty
  a_setup_bytes_ready_irq: assert property (p_setup_bytes_ready_irq) else $error("setup data flag before eighth byte");

  property p_ack;
    sie_status_done |=> s_r.irq_req[B_ACK];
  endproperty
  a_ack: assert property (p_ack) else $error("status stage flag not set");

  property p_out_irq;
    $fell(s_r.ep1o_busy) |-> s_r.ep1_irq[IRQ_EP1O] && $past(sie_ep1o_ok);
  endproperty
  a_out_irq: assert property (p_out_irq) else $error("out busy fell without good data or request");

  property p_out_retry;
    sie_ep1o_tok && s_r.ep1o_busy && !sie_ep1o_ok |=> s_r.ep1o_busy;
  endproperty
  a_out_retry: assert property (p_out_retry) else $error("errored out packet cleared busy");

  property p_arm_out;
    we && s_r.aw_idx == IDX_EP1O_CNT |=> s_r.ep1o_busy && s_axi_bvalid;
  endproperty
  a_arm_out: assert property (p_arm_out) else $error("out count write did not arm");

  property p_stall_out;
    s_r.ep1o_stall |-> ep1o_resp == RESP_STALL;
  endproperty
  a_stall_out: assert property (p_stall_out) else $error("stalled out endpoint not stalling");

  property p_nak_in;
    !s_r.ep1i_stall && !s_r.ep1i_busy |-> ep1i_resp == RESP_NAK;
  endproperty
  a_nak_in: assert property (p_nak_in) else $error("unarmed in endpoint did not nak");

  property p_in_clear;
    $fell(s_r.ep1i_busy) |-> $past(sie_ep1i_ack) && s_r.ep1_irq[IRQ_EP1I];
  endproperty
  a_in_clear: assert property (p_in_clear) else $error("in busy fell without host ack");

  property p_arm_in;
    we && s_r.aw_idx == IDX_EP1I_CNT |=> s_r.ep1i_busy && s_r.ep1i_cnt == $past(s_r.w_data[CNT_W-1:0]);
  endproperty
  a_arm_in: assert property (p_arm_in) else $error("in count write did not arm");

  property p_ipe;
    we && s_r.aw_idx == IDX_IN_PKT_END |=> in_pkt_end_v ##1 !in_pkt_end_v;
  endproperty
  a_ipe: assert property (p_ipe) else $error("in packet end pulse missing");
endmodule

// ### dv/tb_top.sv
// bench: register tasks over AXI4-Lite plus host model events, expected values from the map
// assumes byte address is four times the register index; firmware never touches buffers
`timescale 1ns/1ps
module tb_top
  import usehc_pkg::*;
;
  logic             clk_sys, srst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic             s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [AW-1:0]    s_axi_awaddr, s_axi_araddr;
  logic [31:0]      s_axi_wdata, s_axi_rdata;
  logic [3:0]       s_axi_wstrb;
  logic [1:0]       s_axi_bresp, s_axi_rresp, ep1_irq_flags;
  logic             sie_setup_tok, sie_setup_byte_v, sie_status_done, sie_ep0_done, sie_ep1o_tok;
  logic             sie_ep1o_ok, sie_ep1i_tok, sie_ep1i_ack, ep0_busy, in_pkt_end_v, out_pkt_end_v;
  logic [CNT_W-1:0] sie_ep1o_len, ep1i_count;
  logic [N_LEP-1:0] lep_full, lep_empty, lep_stall;
  logic [2:0]       ctrl_irq_lines;
  logic [7:0]       in_pkt_end_data, out_pkt_end_data, ipe_d, ope_d;
  usehc_resp_t      ep1o_resp, ep1i_resp;
  int               errors = 0, n_checks = 0, ipe_n = 0, ope_n = 0;

  usehc_top uut (
    .clk_sys, .srst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
    .sie_setup_tok, .sie_setup_byte_v, .sie_status_done, .sie_ep0_done, .sie_ep1o_tok, .sie_ep1o_ok,
    .sie_ep1o_len, .sie_ep1i_tok, .sie_ep1i_ack, .lep_full, .lep_empty, .ep1o_resp, .ep1i_resp,
    .ep1i_count, .ep0_busy, .ctrl_irq_lines, .ep1_irq_flags, .lep_stall, .in_pkt_end_v,
    .in_pkt_end_data, .out_pkt_end_v, .out_pkt_end_data
  );

  usehc_host_model host (
    .clk_sys, .ep1o_resp, .ep1i_resp, .sie_setup_tok, .sie_setup_byte_v, .sie_status_done,
    .sie_ep0_done, .sie_ep1o_tok, .sie_ep1o_ok, .sie_ep1o_len, .sie_ep1i_tok, .sie_ep1i_ack
  );

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // packet end strobes last one cycle, so count them as they pass
  always @(posedge clk_sys) begin
    if (in_pkt_end_v) begin
      ipe_n <= ipe_n + 1;
      ipe_d <= in_pkt_end_data;
    end
    if (out_pkt_end_v) begin
      ope_n <= ope_n + 1;
      ope_d <= out_pkt_end_data;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic axw(input logic [15:0] idx, input logic [7:0] dv);
    logic       a, w, b;
    logic [1:0] r;
    b = 1'b0;
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h0, dv};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!b) begin
      @(negedge clk_sys);
      a = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk_sys);
      if (a) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) s_axi_bready <= 1'b0;
    end
    // an edge passes before the next call, and one-cycle strobes get counted by then
    @(posedge clk_sys);
    chk(r, AXI_OKAY);
  endtask

  task automatic rdc(input logic [15:0] idx, input logic [7:0] e, input logic [1:0] er);
    logic        a, done;
    logic [31:0] d;
    logic [1:0]  r;
    done = 1'b0;
    s_axi_araddr <= {idx, 2'b00};
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    while (!done) begin
      @(negedge clk_sys);
      a = s_axi_arvalid && s_axi_arready;
      done = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk_sys);
      if (a) s_axi_arvalid <= 1'b0;
      if (done) s_axi_rready <= 1'b0;
    end
    @(posedge clk_sys);
    chk(d, {24'h0, e});
    chk(r, er);
  endtask

  function automatic logic [7:0] lep_exp(input logic [3:0] f, input logic [3:0] e);
    for (int k = 0; k < N_LEP; k++) lep_exp[2*k +: 2] = {f[k], e[k]};
  endfunction

  initial begin
    repeat (6000) @(posedge clk_sys);
    errors++;
    print_verdict();
  end

  initial begin
    srst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    lep_full = 4'h0;
    lep_empty = 4'hf;
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    rdc(IDX_SEP_BUSY, 8'h00, AXI_OKAY);
    host.ev(4, 7'd8, 1'b1, 0);
    chk(host.o_seen, RESP_NAK);
    host.ev(5, 7'd0, 1'b0, 0);
    chk(host.i_seen, RESP_NAK);
    rdc(16'h0001, 8'h00, AXI_SLVERR);
    axw(IDX_CS_IRQ_EN, 8'h07);
    host.ev(0, 7'd0, 1'b0, 1);
    rdc(IDX_CS_IRQ_REQ, 8'h01, AXI_OKAY);
    for (int i = 0; i < 7; i++) host.ev(1, 7'd0, 1'b0, i % 2);
    rdc(IDX_CS_IRQ_REQ, 8'h01, AXI_OKAY);
    host.ev(1, 7'd0, 1'b0, 0);
    rdc(IDX_CS_IRQ_REQ, 8'h03, AXI_OKAY);
    host.ev(2, 7'd0, 1'b0, 0);
    rdc(IDX_CS_IRQ_REQ, 8'h07, AXI_OKAY);
    axw(IDX_CS_IRQ_EN, 8'h05);
    rdc(IDX_CS_IRQ_EN, 8'h05, AXI_OKAY);
    // a write without byte lane zero must leave the register alone
    s_axi_wstrb <= 4'he;
    axw(IDX_CS_IRQ_EN, 8'h00);
    s_axi_wstrb <= 4'hf;
    rdc(IDX_CS_IRQ_EN, 8'h05, AXI_OKAY);
    chk(ctrl_irq_lines, 3'h5);
    axw(IDX_CS_IRQ_REQ, 8'h07);
    rdc(IDX_CS_IRQ_REQ, 8'h00, AXI_OKAY);
    // endpoint zero arms on any low count write
    axw(IDX_EP0_CNT_LO, 8'h3c);
    rdc(IDX_SEP_BUSY, 8'h01, AXI_OKAY);
    chk(ep0_busy, 1'b1);
    host.ev(3, 7'd0, 1'b0, 0);
    rdc(IDX_SEP_BUSY, 8'h00, AXI_OKAY);
    // endpoint one out: arm, corrupted packet, good packet, stall
    axw(IDX_EP1O_CNT, 8'h7f);
    rdc(IDX_EP1O_CS, 8'h02, AXI_OKAY);
    rdc(IDX_SEP_BUSY, 8'h02, AXI_OKAY);
    host.ev(4, 7'd64, 1'b0, 2);
    chk(host.o_seen, RESP_NAK);
    rdc(IDX_SEP_BUSY, 8'h02, AXI_OKAY);
    chk(ep1_irq_flags, 2'b00);
    host.ev(4, 7'd64, 1'b1, 3);
    chk(host.o_seen, RESP_ACK);
    rdc(IDX_SEP_BUSY, 8'h00, AXI_OKAY);
    rdc(IDX_EP1O_CNT, 8'h40, AXI_OKAY);
    chk(ep1_irq_flags, 2'b01);
    axw(IDX_EP1O_CS, 8'h01);
    host.ev(4, 7'd3, 1'b1, 0);
    chk(host.o_seen, RESP_STALL);
    axw(IDX_EP1O_CS, 8'h00);
    host.ev(4, 7'd3, 1'b1, 0);
    chk(host.o_seen, RESP_NAK);
    // endpoint one in: arm with the full count, stall, then a delivered packet
    axw(IDX_EP1I_CNT, 8'h40);
    chk(ep1i_count, 7'h40);
    rdc(IDX_EP1I_CNT, 8'h40, AXI_OKAY);
    rdc(IDX_SEP_BUSY, 8'h04, AXI_OKAY);
    axw(IDX_EP1I_CS, 8'h01);
    host.ev(5, 7'd0, 1'b0, 0);
    chk(host.i_seen, RESP_STALL);
    rdc(IDX_EP1I_CS, 8'h03, AXI_OKAY);
    axw(IDX_EP1I_CS, 8'h00);
    host.ev(5, 7'd0, 1'b0, 1);
    chk(host.i_seen, RESP_DATA);
    rdc(IDX_SEP_BUSY, 8'h00, AXI_OKAY);
    chk(ep1_irq_flags, 2'b11);
    // large endpoint status copies follow the live levels
    for (int p = 0; p < 2; p++) begin
      lep_full <= p ? 4'h9 : 4'h6;
      lep_empty <= p ? 4'h4 : 4'h1;
      @(posedge clk_sys);
      rdc(IDX_LEP_STAT, lep_exp(lep_full, lep_empty), AXI_OKAY);
      for (int k = 0; k < N_LEP; k++) rdc(IDX_LCS[k], {4'h0, lep_full[k], lep_empty[k], 2'h0}, AXI_OKAY);
    end
    for (int k = 0; k < N_LEP; k++) begin
      axw(IDX_ISO[k], 8'h11 + 8'(k));
      rdc(IDX_ISO[k], 8'h11 + 8'(k), AXI_OKAY);
      axw(IDX_CNT_HI[k], 8'h50 + 8'(k));
      rdc(IDX_CNT_HI[k], 8'h50 + 8'(k), AXI_OKAY);
      axw(IDX_CNT_LO[k], 8'ha0 + 8'(k));
      rdc(IDX_CNT_LO[k], 8'ha0 + 8'(k), AXI_OKAY);
      axw(IDX_LCS[k], 8'h01);
      chk(lep_stall[k], 1'b1);
      rdc(IDX_LCS[k], {4'h0, lep_full[k], lep_empty[k], 2'h1}, AXI_OKAY);
    end
    axw(IDX_IN_PKT_END, 8'h82);
    chk(ipe_n, 1);
    chk(ipe_d, 8'h82);
    axw(IDX_OUT_PKT_END, 8'h86);
    chk(ope_n, 1);
    chk(ope_d, 8'h86);
    print_verdict();
  end
endmodule

// ### dv/usehc_host_model.sv
// host model: turns bus events (tokens, setup bytes, handshakes) into serial engine strobes
// assumes the controller samples every strobe on a rising clk_sys edge
`timescale 1ns/1ps
module usehc_host_model
  import usehc_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire usehc_resp_t      ep1o_resp,
  input  wire usehc_resp_t      ep1i_resp,
  output      logic             sie_setup_tok,
  output      logic             sie_setup_byte_v,
  output      logic             sie_status_done,
  output      logic             sie_ep0_done,
  output      logic             sie_ep1o_tok,
  output      logic             sie_ep1o_ok,
  output      logic [CNT_W-1:0] sie_ep1o_len,
  output      logic             sie_ep1i_tok,
  output      logic             sie_ep1i_ack
);
  usehc_resp_t o_seen;
  usehc_resp_t i_seen;

  initial begin
    {sie_setup_tok, sie_setup_byte_v, sie_status_done, sie_ep0_done} = 4'h0;
    {sie_ep1o_tok, sie_ep1o_ok, sie_ep1i_tok, sie_ep1i_ack} = 4'h0;
    sie_ep1o_len = 7'h2a;
  end

  // e: 0 setup token, 1 setup byte, 2 status done, 3 ep0 done, 4 out packet, 5 in token
  // ok low models a corrupted out packet; gap makes a slow host
  task automatic ev(input int e, input logic [CNT_W-1:0] len, input logic ok, input int gap);
    // one idle edge first, so back-to-back events never re-drive a strobe in the step that lowered it
    repeat (gap + 1) @(posedge clk_sys);
    sie_setup_tok <= (e == 0);
    sie_setup_byte_v <= (e == 1);
    sie_status_done <= (e == 2);
    sie_ep0_done <= (e == 3);
    sie_ep1o_tok <= (e == 4);
    sie_ep1o_ok <= (e == 4) && ok;
    sie_ep1o_len <= (e == 4) ? len : ~sie_ep1o_len;
    sie_ep1i_tok <= (e == 5);
    @(negedge clk_sys);
    o_seen = ep1o_resp;
    i_seen = ep1i_resp;
    @(posedge clk_sys);
    {sie_setup_tok, sie_setup_byte_v, sie_status_done, sie_ep0_done} <= 4'h0;
    {sie_ep1o_tok, sie_ep1o_ok, sie_ep1i_tok} <= 3'h0;
    // length line is released: show the inverse so a stale value never looks valid
    sie_ep1o_len <= ~len;
    // the host acknowledges only data it really received
    if (e == 5 && i_seen === RESP_DATA) begin
      sie_ep1i_ack <= 1'b1;
      @(posedge clk_sys);
      sie_ep1i_ack <= 1'b0;
    end
  endtask
endmodule
